// file: hdl/nlsr_pkg.sv
// constants for the die status reporting block
package nlsr_pkg;

    // command codes
    localparam logic [7:0] CMD_READ_MODE     = 8'h00;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
    localparam logic [7:0] CMD_READ_STAT_ENH = 8'h78;
    localparam logic [7:0] CMD_RESET         = 8'hFF;
    localparam logic [7:0] CMD_SYNC_RESET    = 8'hFC;
    localparam logic [7:0] CMD_SET_FEATURES  = 8'hEF;
    localparam logic [7:0] CMD_GET_FEATURES  = 8'hEE;

    // array operation mode feature
    localparam logic [7:0] FEAT_ADDR_ARRAY_MODE = 8'h90;
    localparam logic [7:0] ARRAY_MODE_RESET     = 8'h00;
    localparam int         ARRAY_MODE_OTP_BIT   = 0;
    localparam logic [1:0] FEAT_PARAM_LAST      = 2'h3;

    // status register layout
    localparam int         SR_WP_BIT         = 7;
    localparam int         SR_RDY_BIT        = 6;
    localparam int         SR_ARRAY_READY_BIT_BIT       = 5;
    localparam int         SR_PRIOR_FAIL_BIT = 1;
    localparam int         SR_LATEST_FAIL_BIT = 0;
    localparam logic [7:0] SR_RESERVED_VALUE = 8'h00;

    // row address layout for the enhanced status read
    localparam logic [1:0] ROW_CYCLES_LAST = 2'h2;
    localparam int         ROW_PLANE_BIT   = 7;
    localparam int         ROW_LUN_BIT     = 4;

    // kinds of finished array operation reported by the core
    localparam logic [1:0] OP_PROGRAM  = 2'h0;
    localparam logic [1:0] OP_COPYBACK = 2'h1;
    localparam logic [1:0] OP_ERASE    = 2'h2;
    localparam logic [1:0] OP_READ     = 2'h3;

    // timing
    localparam int CLK_PERIOD_NS     = 4;
    localparam int STROBE_DELAY_NS   = 20;
    localparam int STROBE_DELAY_CYC  = (STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // pin synchroniser width and idle levels: ce, cle, ale, we, re, wr, wp and dq
    localparam int PIN_SYNC_WIDTH = 15;
    localparam logic [PIN_SYNC_WIDTH-1:0] PIN_IDLE = 15'h4F00;

    typedef enum {
        ST_IDLE,
        ST_ENH_ADDR,
        ST_SETF_ADDR,
        ST_SETF_DATA,
        ST_GETF_ADDR
    } nlsr_state_t;

    typedef enum {
        OUT_NONE,
        OUT_STATUS,
        OUT_FEATURE,
        OUT_PAGE
    } nlsr_out_t;

endpackage

// file: hdl/nlsr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module nlsr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // nlsr_sync

// file: hdl/nlsr_strobe.sv
// data strobe generator: follows the link clock after a fixed delay
`timescale 1ns/100ps
module nlsr_strobe #(
    parameter int DELAY = nlsr_pkg::STROBE_DELAY_CYC
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic link_clk_lvl,
    input  wire logic toggle_en,
    input  wire logic drive_en,
    output logic      dqs_out,
    output logic      dqs_oe
);
    logic [DELAY-1:0] dly_reg;

    // the delay line runs always so the phase is right the moment toggling starts
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dly_reg <= '0;
        end else begin
            dly_reg <= {dly_reg[DELAY-2:0], link_clk_lvl};
        end
    end

    // held low while driven but not toggling
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dqs_out <= 1'b0;
            dqs_oe  <= 1'b0;
        end else begin
            dqs_out <= toggle_en & dly_reg[DELAY-1];
            dqs_oe  <= drive_en;
        end
    end
endmodule // nlsr_strobe

// file: hdl/nlsr_status.sv
// die status register, status output and array operation mode feature
//
// Functional notes
// (RL1) feature 90h bit0 selects OTP array
// (RL2) FFh reset restores normal array mode
// (RL3) each die keeps its own status
// (RL4) 70h/78h enable status on DQ reads
// (RL5) async: status follows while CE#, RE# low
// (RL6) sync: status shown, DQS toggles when captured high
// (RL7) sync captured low: status shown, DQS still
// (RL8) host sends 00h to leave status mode
// (RL9) 70h reports selected die, even busy
// (RL10) multi-die host uses 78h, not 70h
// (RL11) bit7 write protect, WP# or OTP fault
// (RL12) bit6 ready-io; busy accepts only FF/FC/70/78
// (RL13) bit5 array-ready across all planes
// (RL14) bit1 previous program/copyback failed
// (RL15) bit0 latest program/erase/copyback failed
// (RL16) 70h ORs planes, 78h one plane
// (RL17) host polls 78h per plane after fail
// (RL18) 78h plus three rows selects die
// (RL19) enhanced: shared ready bits, plane fail bits
// (RL20) 78h enables die data output; 00h before data
// (RL21) host avoids 78h in reset or OTP
// (RL22) bits 4..2 zero; reserved feature bits ignored
`timescale 1ns/100ps
module nlsr_status #(
    parameter int         NUM_PLANES = 2,
    parameter logic       LUN_ADDR   = 1'b0,
    parameter int         STROBE_DLY = nlsr_pkg::STROBE_DELAY_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic                  ce_n_pin,
    input  wire logic                  cle_pin,
    input  wire logic                  ale_pin,
    input  wire logic                  we_n_pin,
    input  wire logic                  re_n_pin,
    input  wire logic                  wr_n_pin,
    input  wire logic                  wp_n_pin,
    input  wire logic [7:0]            dq_in,
    output logic      [7:0]            dq_out,
    output logic                       dq_oe,
    output logic                       dqs_out,
    output logic                       dqs_oe,
    input  wire logic                  sync_mode,
    input  wire logic                  io_busy,
    input  wire logic [NUM_PLANES-1:0] plane_busy,
    input  wire logic                  op_done,
    input  wire logic [1:0]            op_kind,
    input  wire logic [NUM_PLANES-1:0] op_planes,
    input  wire logic [NUM_PLANES-1:0] op_fail,
    input  wire logic                  otp_prot_fail,
    output logic                       array_mode_otp,
    output logic                       page_out_en,
    output logic                       die_selected,
    output logic      [7:0]            die_status
);
    import nlsr_pkg::*;

    localparam int PW = (NUM_PLANES > 1) ? $clog2(NUM_PLANES) : 1;

    function automatic logic plane_or(input logic [NUM_PLANES-1:0] bits,
                                      input logic [NUM_PLANES-1:0] mask);
        plane_or = |(bits & mask);
    endfunction

    // ---------------- pin synchronisation and edge detection
    logic [PIN_SYNC_WIDTH-1:0] pins_s;
    logic       ce_n_s, cle_s, ale_s, we_n_s, re_n_s, wr_n_s, wp_n_s;
    logic [7:0] dq_s;
    logic       we_n_d;
    logic       re_n_d;

    nlsr_sync #(
        .WIDTH (PIN_SYNC_WIDTH)
    ) u_pin_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in ({ce_n_pin, cle_pin, ale_pin, we_n_pin, re_n_pin, wr_n_pin,
                    wp_n_pin, dq_in} ^ PIN_IDLE),
        .sync_out (pins_s)
    );

    assign {ce_n_s, cle_s, ale_s, we_n_s, re_n_s, wr_n_s, wp_n_s, dq_s} = pins_s ^ PIN_IDLE;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            we_n_d <= 1'b1;
            re_n_d <= 1'b1;
        end else begin
            we_n_d <= we_n_s;
            re_n_d <= re_n_s;
        end
    end

    // latch edge of WE# (async) or CLK (sync), and end of a read request
    logic we_rise;
    logic re_rise;
    logic cmd_cycle;
    logic addr_cycle;
    logic data_cycle;

    assign we_rise    = we_n_s & ~we_n_d & ~ce_n_s;
    assign re_rise    = re_n_s & ~re_n_d & ~ce_n_s;
    assign cmd_cycle  = we_rise & cle_s & ~ale_s;
    assign addr_cycle = we_rise & ale_s & ~cle_s;
    assign data_cycle = we_rise & ~ale_s & ~cle_s;

    // ---------------- command acceptance
    logic [7:0] cmd;
    logic       cmd_ok;

    assign cmd = dq_s;
    // while busy only the reset and status commands get through
    assign cmd_ok = cmd_cycle & (~io_busy | (cmd == CMD_RESET) |
                    (cmd == CMD_SYNC_RESET) | (cmd == CMD_READ_STATUS) |
                    (cmd == CMD_READ_STAT_ENH)); // RL12

    // ---------------- command sequencer
    nlsr_state_t state_reg;
    logic [1:0]  cyc_cnt_reg;
    logic [7:0]  feat_addr_reg;
    logic        enh_plane_hit_reg;
    logic [PW-1:0] enh_plane_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg   <= ST_IDLE;
            cyc_cnt_reg <= 2'h0;
        end else if (cmd_ok) begin
            cyc_cnt_reg <= 2'h0;
            case (cmd)
                CMD_READ_STAT_ENH: state_reg <= ST_ENH_ADDR;
                CMD_SET_FEATURES:  state_reg <= ST_SETF_ADDR;
                CMD_GET_FEATURES:  state_reg <= ST_GETF_ADDR;
                default:           state_reg <= ST_IDLE;
            endcase
        end else begin
            case (state_reg)
                ST_ENH_ADDR: begin
                    if (addr_cycle) begin
                        cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
                        if (cyc_cnt_reg == ROW_CYCLES_LAST) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_SETF_ADDR: begin
                    if (addr_cycle) begin
                        state_reg <= ST_SETF_DATA;
                    end
                end
                ST_SETF_DATA: begin
                    if (data_cycle) begin
                        cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
                        if (cyc_cnt_reg == FEAT_PARAM_LAST) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_GETF_ADDR: begin
                    if (addr_cycle) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            feat_addr_reg <= 8'h00;
        end else if (addr_cycle && (state_reg == ST_SETF_ADDR || state_reg == ST_GETF_ADDR)) begin
            feat_addr_reg <= dq_s;
        end
    end

    // plane of the enhanced read comes from the first row cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            enh_plane_reg <= '0;
        end else if (addr_cycle && state_reg == ST_ENH_ADDR && cyc_cnt_reg == 2'h0) begin
            enh_plane_reg <= PW'(dq_s[ROW_PLANE_BIT]); // RL19
        end
    end

    assign enh_plane_hit_reg = addr_cycle && (state_reg == ST_ENH_ADDR) &&
                               (cyc_cnt_reg == ROW_CYCLES_LAST);

    // ---------------- die selection and output mode
    logic      selected_reg;
    logic      enhanced_reg;
    nlsr_out_t out_mode_reg;
    logic      lun_match;

    assign lun_match = (dq_s[ROW_LUN_BIT] == LUN_ADDR);

    // a single die answers 70h from reset; 78h moves the selection
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            selected_reg <= 1'b1;
        end else if (enh_plane_hit_reg) begin
            selected_reg <= lun_match; // RL18
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_mode_reg <= OUT_NONE;
            enhanced_reg <= 1'b0;
        end else if (enh_plane_hit_reg) begin
            out_mode_reg <= lun_match ? OUT_STATUS : OUT_NONE; // RL18
            enhanced_reg <= 1'b1; // RL16
        end else if (addr_cycle && state_reg == ST_GETF_ADDR) begin
            out_mode_reg <= OUT_FEATURE;
        end else if (cmd_ok) begin
            case (cmd)
                CMD_READ_STATUS: begin
                    // busy or not, the last selected die answers
                    out_mode_reg <= selected_reg ? OUT_STATUS : OUT_NONE; // RL9
                    enhanced_reg <= 1'b0; // RL16
                end
                CMD_READ_STAT_ENH: out_mode_reg <= OUT_NONE;
                // leaving status restores page data output on the selected die
                CMD_READ_MODE: out_mode_reg <= selected_reg ? OUT_PAGE : OUT_NONE; // RL20
                default:       out_mode_reg <= OUT_NONE;
            endcase
        end
    end

    // ---------------- array operation mode feature
    logic array_mode_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            array_mode_reg <= ARRAY_MODE_RESET[ARRAY_MODE_OTP_BIT];
        end else if (cmd_ok && cmd == CMD_RESET) begin
            array_mode_reg <= ARRAY_MODE_RESET[ARRAY_MODE_OTP_BIT]; // RL2
        end else if (data_cycle && state_reg == ST_SETF_DATA && cyc_cnt_reg == 2'h0 &&
                     feat_addr_reg == FEAT_ADDR_ARRAY_MODE) begin
            // only bit 0 is kept, reserved bits are dropped
            array_mode_reg <= dq_s[ARRAY_MODE_OTP_BIT]; // RL1 RL22
        end
    end

    // ---------------- status sources
    logic                  otp_unprot_reg;
    logic [NUM_PLANES-1:0] latest_fail_reg;
    logic [NUM_PLANES-1:0] prior_fail_reg;
    logic [NUM_PLANES-1:0] active_planes_reg;
    logic                  fail_tracked;

    // OTP fault marker restarts each time OTP mode is (re)entered
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            otp_unprot_reg <= 1'b1;
        end else if (!array_mode_reg) begin
            otp_unprot_reg <= 1'b1;
        end else if (otp_prot_fail) begin
            otp_unprot_reg <= 1'b0; // RL11
        end
    end

    assign fail_tracked = op_done & (op_kind != OP_READ);

    // per plane history; reads leave the fail bits untouched
    genvar p;
    generate
        for (p = 0; p < NUM_PLANES; p++) begin : g_plane
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    latest_fail_reg[p] <= 1'b0;
                    prior_fail_reg[p]  <= 1'b0;
                end else if (fail_tracked && op_planes[p]) begin
                    latest_fail_reg[p] <= op_fail[p]; // RL15
                    // erase is outside the previous-op history
                    if (op_kind != OP_ERASE) begin
                        prior_fail_reg[p] <= latest_fail_reg[p]; // RL14
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            active_planes_reg <= '0;
        end else if (fail_tracked) begin
            active_planes_reg <= op_planes;
        end
    end

    // ---------------- status register assembly
    logic [NUM_PLANES-1:0] plane_mask;
    logic [7:0]            status_next;

    always_comb begin
        plane_mask = '0;
        plane_mask[enh_plane_reg] = 1'b1;
        if (!enhanced_reg) begin
            plane_mask = active_planes_reg; // RL16
        end
        status_next = SR_RESERVED_VALUE; // RL22
        status_next[SR_WP_BIT] = array_mode_reg ? otp_unprot_reg : wp_n_s; // RL11
        status_next[SR_RDY_BIT] = ~io_busy; // RL12
        // ready bits shared by all planes of this die
        status_next[SR_ARRAY_READY_BIT_BIT] = ~(|plane_busy); // RL13 RL19
        status_next[SR_PRIOR_FAIL_BIT] = plane_or(prior_fail_reg, plane_mask); // RL14 RL19
        status_next[SR_LATEST_FAIL_BIT] = plane_or(latest_fail_reg, plane_mask); // RL15 RL19
    end

    // this die's own register, never shared with another die
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            die_status <= SR_RESERVED_VALUE;
        end else begin
            die_status <= status_next; // RL3
        end
    end

    // ---------------- feature read index
    logic [1:0] feat_idx_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            feat_idx_reg <= 2'h0;
        end else if (out_mode_reg != OUT_FEATURE) begin
            feat_idx_reg <= 2'h0;
        end else if (re_rise && feat_idx_reg != FEAT_PARAM_LAST) begin
            feat_idx_reg <= feat_idx_reg + 2'h1;
        end
    end

    // ---------------- DQ output
    logic out_active;
    logic async_drive;
    logic sync_drive;
    logic [7:0] out_byte;

    assign out_active  = (out_mode_reg == OUT_STATUS) || (out_mode_reg == OUT_FEATURE);
    assign async_drive = ~sync_mode & ~ce_n_s & ~re_n_s; // RL5
    assign sync_drive  = sync_mode & ~ce_n_s & ~wr_n_s; // RL6 RL7

    always_comb begin
        out_byte = 8'h00;
        if (out_mode_reg == OUT_STATUS) begin
            out_byte = die_status; // RL4
        end else if (feat_idx_reg == 2'h0 && feat_addr_reg == FEAT_ADDR_ARRAY_MODE) begin
            out_byte[ARRAY_MODE_OTP_BIT] = array_mode_reg;
        end
    end

    // refreshed every cycle so live status changes reach the pins without new requests
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dq_out <= 8'h00;
            dq_oe  <= 1'b0;
        end else begin
            dq_out <= out_byte; // RL4 RL5
            dq_oe  <= out_active & (async_drive | sync_drive); // RL5 RL6 RL7
        end
    end

    // ---------------- DQS in synchronous mode
    logic cap_hi_reg;

    // ALE and CLE captured at the link clock rising edge; a deselect forgets them
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cap_hi_reg <= 1'b0;
        end else if (ce_n_s | (we_n_s & ~we_n_d)) begin
            cap_hi_reg <= ~ce_n_s & ale_s & cle_s;
        end
    end

    nlsr_strobe #(
        .DELAY (STROBE_DLY)
    ) u_strobe (
        .core_clk     (core_clk),
        .reset        (reset),
        .link_clk_lvl (we_n_s),
        .toggle_en    (out_active & sync_drive & cap_hi_reg), // RL6 RL7
        .drive_en     (out_active & sync_drive),
        .dqs_out      (dqs_out),
        .dqs_oe       (dqs_oe)
    );

    assign array_mode_otp = array_mode_reg;
    assign page_out_en    = (out_mode_reg == OUT_PAGE);
    assign die_selected   = selected_reg;

endmodule // nlsr_status

// file: tb/nlsr_status_props.sv
// assertions on the die status reporting ports
`timescale 1ns/100ps
module nlsr_status_props
    import nlsr_pkg::*;
#(
    parameter int NUM_PLANES = 2
) (
    input wire logic                  core_clk,
    input wire logic                  reset,
    input wire logic                  ce_n_pin,
    input wire logic                  re_n_pin,
    input wire logic                  wp_n_pin,
    input wire logic                  sync_mode,
    input wire logic                  io_busy,
    input wire logic [NUM_PLANES-1:0] plane_busy,
    input wire logic                  otp_prot_fail,
    input wire logic                  array_mode_otp,
    input wire logic [7:0]            die_status,
    input wire logic                  dq_oe,
    input wire logic                  dqs_out,
    input wire logic                  dqs_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    rsvd_zero_a: assert property (die_status[4:2] == 3'h0)
        else $error("reserved status bits set");
    // the past guard skips the first edge, whose sample still sees reset
    ready_bit_a: assert property (
        !$past(reset) |-> die_status[SR_RDY_BIT] == !$past(io_busy)) else $error("ready bit");
    array_ready_a: assert property (
        !$past(reset) |-> die_status[SR_ARRAY_READY_BIT_BIT] == ~|$past(plane_busy)) else $error("array bit");
    // pin passes two sync flops, so allow three settling cycles
    wp_mirror_a: assert property (
        $changed(wp_n_pin) ##1 ($stable(wp_n_pin) && !array_mode_otp)[*3]
        |-> die_status[SR_WP_BIT] == wp_n_pin) else $error("protect bit");
    otp_protect_a: assert property (
        array_mode_otp && otp_prot_fail |-> ##[1:2] !die_status[SR_WP_BIT]) else $error("otp bit");
    ce_off_a: assert property (ce_n_pin[*5] |-> !dq_oe)
        else $error("dq driven with chip disabled");
    re_off_a: assert property ((re_n_pin && !sync_mode)[*5] |-> !dq_oe)
        else $error("dq driven without read request");
    async_dqs_a: assert property ((!sync_mode)[*8] |-> !dqs_oe)
        else $error("strobe driven in async mode");
    dqs_owned_a: assert property ($rose(dqs_out) |-> dqs_oe)
        else $error("strobe toggles undriven");

    read_cov_c: cover property ($rose(dq_oe) && !sync_mode);
    strobe_cov_c: cover property ($rose(dqs_out));
    otp_cov_c: cover property ($rose(array_mode_otp));
endmodule // nlsr_status_props

bind nlsr_status nlsr_status_props #(.NUM_PLANES(NUM_PLANES)) chk_u (
    .core_clk, .reset, .ce_n_pin, .re_n_pin, .wp_n_pin, .sync_mode, .io_busy, .plane_busy,
    .otp_prot_fail, .array_mode_otp, .die_status, .dq_oe, .dqs_out, .dqs_oe
);

// file: tb/nlsr_host_model.sv
// host controller model driving the flash pins
`timescale 1ns/100ps
module nlsr_host_model
    import nlsr_pkg::*;
(
    input  wire logic core_clk,
    output logic      ce_n,
    output logic      cle,
    output logic      ale,
    output logic      we_n,
    output logic      re_n,
    output logic      wr_n,
    output logic [7:0] dq
);
    initial begin
        {ce_n, cle, ale, we_n, re_n, wr_n} = 6'h27;
        dq = 8'h00;
    end
    // kind 1 command, 2 address, 0 data; 6 cycles a phase is the 48 ns link period
    task automatic xfer(input logic [1:0] kind, input logic [7:0] val);
        @(posedge core_clk);
        {ce_n, ale, cle, we_n, dq} <= {1'b0, kind, 1'b0, val};
        repeat (6) @(posedge core_clk);
        we_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        // a released bus shows the inverse so stale data cannot pass
        {ale, cle, dq} <= {2'h0, ~val};
    endtask
    task automatic setf(input logic [7:0] addr, input logic [7:0] p1);
        xfer(2'h1, CMD_SET_FEATURES);
        xfer(2'h2, addr);
        xfer(2'h0, p1);
        repeat (3) xfer(2'h0, 8'h00);
    endtask
    task automatic status_enh(input logic plane, input logic lun);
        xfer(2'h1, CMD_READ_STAT_ENH);
        xfer(2'h2, {plane, 7'h00});
        xfer(2'h2, 8'h00);
        xfer(2'h2, {3'h0, lun, 4'h0});
    endtask
    task automatic re(input logic lvl);
        @(posedge core_clk);
        {ce_n, re_n} <= {lvl, lvl};
        repeat (8) @(posedge core_clk);
    endtask
    // clock stands still outside the burst
    task automatic sync_out(input logic s);
        @(posedge core_clk);
        {ce_n, wr_n, cle, ale} <= {2'h0, s, s};
        repeat (8) begin
            repeat (6) @(posedge core_clk);
            we_n <= ~we_n;
        end
        repeat (6) @(posedge core_clk);
        {ce_n, wr_n, cle, ale} <= 4'hC;
        repeat (12) @(posedge core_clk);
    endtask
endmodule // nlsr_host_model

// file: tb/nlsr_tb.sv
// self-checking bench for the die status reporting block
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
module tb;
    import nlsr_pkg::*;
    logic       core_clk = 1'b0;
    logic       reset = 1'b1;
    logic       sync_mode = 1'b0, io_busy = 1'b0, op_done = 1'b0, otp_prot_fail = 1'b0;
    logic       wp_n_pin = 1'b1, oe_d = 1'b0, dqs_d = 1'b0;
    logic [1:0] plane_busy = 2'h0, op_kind = 2'h0, op_fail = 2'h0, lat = 2'h0, pri = 2'h0;
    logic [1:0] op_planes = 2'h3;
    logic       ce_n, cle, ale, we_n, re_n, wr_n, dq_oe, dqs_out, dqs_oe, otp, page_en, sel;
    logic [7:0] dq_host, dq_out, die_status, out_d, out_x, f;
    logic [7:0] exp_q[$];
    logic [2:0] walk = 3'h1;
    int         errors = 0, checked = 0, cycles = 0, dqs_rises = 0;
    integer     seed = 32'h6756;

    initial begin
        forever #2 core_clk = ~core_clk;
    end
    nlsr_host_model host_u (.core_clk, .ce_n, .cle, .ale, .we_n, .re_n, .wr_n, .dq(dq_host));
    nlsr_status dut_u (
        .core_clk, .reset, .ce_n_pin(ce_n), .cle_pin(cle), .ale_pin(ale), .we_n_pin(we_n),
        .re_n_pin(re_n), .wr_n_pin(wr_n), .wp_n_pin, .dq_in(dq_host), .dq_out, .dq_oe,
        .dqs_out, .dqs_oe, .sync_mode, .io_busy, .plane_busy, .op_done, .op_kind, .op_planes,
        .op_fail, .otp_prot_fail, .array_mode_otp(otp), .page_out_en(page_en),
        .die_selected(sel), .die_status
    );

    task automatic complete_run();
        if (errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] e);
        exp_q.push_back(e);
        host_u.re(1'b0);
        host_u.re(1'b1);
    endtask

    // every rise of dq_oe and every change while driven consumes one note
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (dqs_out === 1'b1 && dqs_d === 1'b0) dqs_rises++;
        if (dq_oe === 1'b1 && (oe_d !== 1'b1 || dq_out !== out_d)) begin
            out_x = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            `CHK("dq_out", out_x, dq_out)
        end
        oe_d <= dq_oe;
        out_d <= dq_out;
        dqs_d <= dqs_out;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK("otp", 1'b0, otp)
        `CHK("selected", 1'b1, sel)
        `CHK("status", 8'hE0, die_status)
        host_u.xfer(2'h1, CMD_READ_STATUS);
        rd_chk(8'hE0);
        exp_q.push_back(8'hE0);
        host_u.re(1'b0);
        // one bit flips a step
        repeat (6) begin
            f = 8'($random(seed));
            walk = walk ^ (3'h1 << (f % 8'h03));
            exp_q.push_back({walk[0], ~walk[1], ~walk[2], 5'h00});
            {plane_busy[0], io_busy, wp_n_pin} <= walk;
            repeat (8) @(posedge core_clk);
        end
        host_u.re(1'b1);
        {plane_busy[0], io_busy, wp_n_pin} <= 3'h1;
        host_u.xfer(2'h1, CMD_READ_MODE);
        `CHK("page out", 1'b1, page_en)
        host_u.re(1'b0);
        host_u.re(1'b1);
        io_busy <= 1'b1;
        host_u.setf(FEAT_ADDR_ARRAY_MODE, 8'h01);
        `CHK("busy feature", 1'b0, otp)
        host_u.xfer(2'h1, CMD_READ_STATUS);
        rd_chk(8'hA0);
        io_busy <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            f = 8'($random(seed));
            {op_done, op_kind, op_fail} <= {1'b1, f[3:0]};
            @(posedge core_clk);
            op_done <= 1'b0;
            if (f[3:2] < OP_ERASE) pri = lat;
            if (f[3:2] != OP_READ) lat = f[1:0];
            host_u.xfer(2'h1, CMD_READ_STATUS);
            rd_chk({6'h38, |pri, |lat});
        end
        for (int p = 0; p < 2; p++) begin
            host_u.status_enh(p[0], 1'b0);
            rd_chk({6'h38, pri[p], lat[p]});
        end
        host_u.status_enh(1'b0, 1'b1);
        `CHK("deselect", 1'b0, sel)
        host_u.xfer(2'h1, CMD_READ_STATUS);
        host_u.re(1'b0);
        host_u.re(1'b1);
        host_u.status_enh(1'b0, 1'b0);
        host_u.setf(8'h01, 8'h01);
        `CHK("other feature", 1'b0, otp)
        host_u.setf(FEAT_ADDR_ARRAY_MODE, 8'hFF);
        `CHK("otp mode", 1'b1, otp)
        host_u.xfer(2'h1, CMD_GET_FEATURES);
        host_u.xfer(2'h2, FEAT_ADDR_ARRAY_MODE);
        rd_chk(8'h01);
        otp_prot_fail <= 1'b1;
        @(posedge core_clk);
        otp_prot_fail <= 1'b0;
        host_u.xfer(2'h1, CMD_READ_STATUS);
        rd_chk({6'h18, |pri, |lat});
        // no enhanced read here: it is barred while the otp array is chosen
        host_u.xfer(2'h1, CMD_RESET);
        `CHK("otp cleared", 1'b0, otp)
        sync_mode <= 1'b1;
        host_u.xfer(2'h1, CMD_READ_STATUS);
        exp_q.push_back({6'h38, |pri, |lat});
        dqs_rises = 0;
        host_u.sync_out(1'b1);
        `CHK("strobe toggles", 1'b1, dqs_rises > 0)
        exp_q.push_back({6'h38, |pri, |lat});
        dqs_rises = 0;
        host_u.sync_out(1'b0);
        `CHK("strobe quiet", 0, dqs_rises)
        sync_mode <= 1'b0;
        `CHK("drained", 0, exp_q.size())
        complete_run();
    end
endmodule // tb
